// ===== rtl/csb_pkg.sv
package csb_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [31:0] REGION3_BASE_ADDRESS = 32'h8007fdd0;
	localparam logic [31:0] REGION3_OPTIONS = 32'h8007fdd4;
	localparam logic [31:0] REGION2_BASE_ADDRESS = 32'h8007fdd8;
	localparam logic [31:0] REGION2_OPTIONS = 32'h8007fddc;
	localparam logic [31:0] REGION1_BASE_ADDRESS = 32'h8007fde0;
	localparam logic [31:0] REGION1_OPTIONS = 32'h8007fde4;
	localparam logic [31:0] SYSTEM_UNIT_CONFIG = 32'h8007fde8;
	localparam logic [31:0] BUS_STATUS = 32'h8007fdec;

	// ==========================================================
	// Option register field positions and the config burst bit
	localparam int DEPTH_LSB = 0;
	localparam int ACK_BIT = 4;
	localparam int PWIDTH_LSB = 5;
	localparam int PFUNC_LSB = 7;
	localparam int BYTE_LSB = 9;
	localparam int REGION_LSB = 11;
	localparam int INTERFACE_TYPE_FIELD_LSB = 14;
	localparam int BURST_END_BIT = 4;

	// ==========================================================
	// Field codes and reset values
	localparam logic [3:0] DEPTH_128K = 4'h6;
	localparam logic [3:0] DEPTH_MAX = 4'hd;
	localparam logic [1:0] PWIDTH_32 = 2'h2;
	localparam logic [1:0] PWIDTH_16 = 2'h1;
	localparam logic [1:0] PF_CHIP = 2'h0;
	localparam logic [1:0] PF_WRITE = 2'h1;
	localparam logic [1:0] PF_OUTPUT = 2'h2;
	localparam logic [3:0] INTERFACE_TYPE_FIELD_SYNC_AOE = 4'h5;
	localparam logic [31:0] BASE_RESET = 32'h00000000;
	localparam logic [31:0] OPT_RESET = 32'h00000000;
	localparam logic [31:0] CFG_RESET = 32'h00000000;
	localparam int NUM_REGIONS = 3;
	localparam int DEPTH_BASE_LOG2 = 11;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [3:0] interface_type_field;
		logic [2:0] region;
		logic [1:0] byte_sel;
		logic [1:0] pin_function;
		logic [1:0] port_width;
		logic ack_gate;
		logic [3:0] depth;
	} csb_opt_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [3:0] lane_en;
		logic burst;
		logic last;
	} csb_xfer_type;

endpackage

// ===== rtl/csb_match.sv
`timescale 1ns/1ps
module csb_match
	import csb_pkg::*;
(
	// Region setup
	input wire logic [31:0] base_i,
	input wire logic [3:0] depth_i,
	// Access
	input wire logic [31:0] addr_i,
	output logic hit_o
);
	// ==========================================================
	// Window compare
	logic [31:0] mask;
	logic [4:0] sh;
	// Depth code n (codes above 1101 clamp to 1101) maps 2^(n+11) bytes; 0110 gives 128KB
	always_comb begin
		sh = 5'(DEPTH_BASE_LOG2) + {1'b0, (depth_i > DEPTH_MAX) ? DEPTH_MAX : depth_i};
		mask = 32'hffffffff << sh;
		hit_o = ((addr_i & mask) == (base_i & mask));
	end
endmodule

// ===== rtl/csb_pin.sv
`timescale 1ns/1ps
module csb_pin
	import csb_pkg::*;
(
	// Configuration
	input wire logic [1:0] func_i,
	// Qualifiers
	input wire logic own_hit_i,
	input wire logic pair_hit_i,
	input wire logic write_i,
	input wire logic valid_i,
	output logic assert_o
);
	// ==========================================================
	// Pin function select
	always_comb begin
		unique case (func_i)
			PF_CHIP: assert_o = valid_i && own_hit_i;
			PF_WRITE: assert_o = valid_i && pair_hit_i && write_i;
			PF_OUTPUT: assert_o = valid_i && pair_hit_i && !write_i;
			default: assert_o = 1'b0;
		endcase
	end
endmodule

// ===== rtl/csb_port.sv
`timescale 1ns/1ps
module csb_port
	import csb_pkg::*;
#(
	parameter int NUM_CS = NUM_REGIONS
)(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire logic [31:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Internal transfer request (same clock)
	input wire csb_xfer_type xfer_i,
	// External bus pins
	output logic [31:0] bus_addr_o,
	output logic [3:0] byte_lane_enable_n_o,
	output logic [NUM_CS-1:0] cs_n_o,
	output logic transfer_start_strobe_n_o,
	output logic burst_continue_out_n_o,
	output logic ack_enabled_o
);
	// ==========================================================
	// Registers
	logic [31:0] base [NUM_CS];
	csb_opt_type opt [NUM_CS];
	logic [31:0] sys_cfg;
	logic [31:0] rdata;
	logic [31:0] next_base [NUM_CS];
	csb_opt_type next_opt [NUM_CS];
	logic [31:0] next_sys_cfg;
	logic [31:0] next_rdata;
	logic [31:0] base_addr [NUM_CS];
	logic [31:0] opt_addr [NUM_CS];
	logic [NUM_CS-1:0] hit;
	logic [NUM_CS-1:0] pin_on;
	logic [NUM_CS-1:0] ack_on;
	logic [31:0] status;

	// Offsets step down by eight per region number
	always_comb begin
		for (int i = 0; i < NUM_CS; i++) begin
			base_addr[i] = REGION1_BASE_ADDRESS - 32'(8 * i);
			opt_addr[i] = REGION1_OPTIONS - 32'(8 * i);
		end
	end

	// Register write and read decode; unmapped reads return zero
	always_comb begin
		next_sys_cfg = sys_cfg;
		next_rdata = 32'h00000000;
		for (int i = 0; i < NUM_CS; i++) begin
			next_base[i] = base[i];
			next_opt[i] = opt[i];
			if (reg_wr_i && reg_addr_i == base_addr[i])
				next_base[i] = reg_wdata_i;
			if (reg_wr_i && reg_addr_i == opt_addr[i])
				next_opt[i] = csb_opt_type'(reg_wdata_i[17:0]);
			if (reg_rd_i && reg_addr_i == base_addr[i])
				next_rdata = base[i];
			if (reg_rd_i && reg_addr_i == opt_addr[i])
				next_rdata = {14'h0000, opt[i]};
		end
		if (reg_wr_i && reg_addr_i == SYSTEM_UNIT_CONFIG)
			next_sys_cfg = reg_wdata_i;
		if (reg_rd_i && reg_addr_i == SYSTEM_UNIT_CONFIG)
			next_rdata = sys_cfg;
		if (reg_rd_i && reg_addr_i == BUS_STATUS)
			next_rdata = status;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NUM_CS; i++) begin
				base[i] <= BASE_RESET;
				opt[i] <= csb_opt_type'(OPT_RESET[17:0]);
			end
			sys_cfg <= CFG_RESET;
			rdata <= 32'h00000000;
		end else begin
			base <= next_base;
			opt <= next_opt;
			sys_cfg <= next_sys_cfg;
			rdata <= next_rdata;
		end
	end
	assign reg_rdata_o = rdata;

	// ==========================================================
	// Per-pin region decode and function
	genvar g;
	generate
		for (g = 0; g < NUM_CS; g++) begin : g_cs
			logic pair_hit;
			csb_match u_match (
				.base_i(base[g]),
				.depth_i(opt[g].depth),
				.addr_i(xfer_i.addr),
				.hit_o(hit[g])
			);
			// Paired chip enable index; code 001 is region 1 (index 0)
			always_comb begin
				pair_hit = 1'b0;
				for (int k = 0; k < NUM_CS; k++)
					if (opt[g].region == 3'(k + 1))
						pair_hit = hit[k];
			end
			csb_pin u_pin (
				.func_i(opt[g].pin_function),
				.own_hit_i(hit[g]),
				.pair_hit_i(pair_hit),
				.write_i(xfer_i.write),
				.valid_i(xfer_i.valid),
				.assert_o(pin_on[g])
			);
			// Acknowledge only when gate field set
			assign ack_on[g] = pin_on[g] && opt[g].ack_gate;
		end
	endgenerate

	// ==========================================================
	// Bus pins: byte field ignored, port width trims lanes
	logic [NUM_CS-1:0] next_cs_n;
	logic [3:0] next_lanes_n;
	logic [31:0] next_addr;
	logic next_ts_n;
	logic next_burst_n;
	logic next_ack;
	logic any_on;
	logic narrow;
	always_comb begin
		any_on = |pin_on;
		narrow = 1'b0;
		for (int i = 0; i < NUM_CS; i++)
			if (pin_on[i] && opt[i].pin_function == PF_CHIP && opt[i].port_width == PWIDTH_16)
				narrow = 1'b1;
		next_cs_n = ~pin_on;
		next_addr = xfer_i.addr;
		next_lanes_n = 4'hf;
		if (any_on)
			next_lanes_n = narrow ? {2'h3, ~xfer_i.lane_en[1:0]} : ~xfer_i.lane_en;
		next_ts_n = !(xfer_i.valid && any_on);
		// Config bit picks final-beat or burst-in-progress meaning
		if (sys_cfg[BURST_END_BIT])
			next_burst_n = !(any_on && xfer_i.last);
		else
			next_burst_n = !(any_on && xfer_i.burst && !xfer_i.last);
		next_ack = |ack_on;
	end

	// Registered so every pin changes on the bus clock edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cs_n_o <= '1;
			byte_lane_enable_n_o <= 4'hf;
			bus_addr_o <= 32'h00000000;
			transfer_start_strobe_n_o <= 1'b1;
			burst_continue_out_n_o <= 1'b1;
			ack_enabled_o <= 1'b0;
		end else begin
			cs_n_o <= next_cs_n;
			byte_lane_enable_n_o <= next_lanes_n;
			bus_addr_o <= next_addr;
			transfer_start_strobe_n_o <= next_ts_n;
			burst_continue_out_n_o <= next_burst_n;
			ack_enabled_o <= next_ack;
		end
	end

	// Status: sync type seen in region 1 and live hits
	always_comb begin
		status = 32'h00000000;
		status[NUM_CS-1:0] = hit;
		status[8] = (opt[0].interface_type_field == INTERFACE_TYPE_FIELD_SYNC_AOE);
	end

	// ==========================================================
	// Checks
	a_cs_inactive_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!xfer_i.valid |=> cs_n_o == '1) else $error("chip select active without transfer");
	a_lanes_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!xfer_i.valid |=> byte_lane_enable_n_o == 4'hf) else $error("lanes active idle");
	a_cs_in_window: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(xfer_i.valid && opt[0].pin_function == PF_CHIP && !hit[0]) |=> cs_n_o[0])
		else $error("chip select outside window");
	a_cs_hit_asserts: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(xfer_i.valid && opt[0].pin_function == PF_CHIP && hit[0]) |=> !cs_n_o[0])
		else $error("chip select missing in window");
	a_oe_no_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(xfer_i.write && opt[NUM_CS-1].pin_function == PF_OUTPUT) |=> cs_n_o[NUM_CS-1])
		else $error("output enable during write");
	a_ack_gate_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(opt[0].ack_gate == 1'b0 && opt[1].ack_gate == 1'b0 && opt[2].ack_gate == 1'b0)
		|=> !ack_enabled_o) else $error("ack while disabled");
	a_last_select: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(sys_cfg[BURST_END_BIT] && any_on && xfer_i.last) |=> !burst_continue_out_n_o)
		else $error("final beat not shown");
	a_addr_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		xfer_i.valid |=> bus_addr_o == $past(xfer_i.addr)) else $error("address mismatch");
	a_narrow_lanes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		narrow |=> byte_lane_enable_n_o[3:2] == 2'h3) else $error("x16 upper lanes");
	a_start_strobe: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(xfer_i.valid && any_on) |=> !transfer_start_strobe_n_o) else $error("no start");
	// Lanes follow their own enables on a full-width port
	a_lanes_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(any_on && !narrow) |=> byte_lane_enable_n_o == ~$past(xfer_i.lane_en))
		else $error("lane enable mapping");
	a_strobe_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!any_on |=> transfer_start_strobe_n_o) else $error("start strobe without hit");
	a_ack_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(|ack_on) |=> ack_enabled_o) else $error("ack missing while enabled");
	a_burst_mid: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!sys_cfg[BURST_END_BIT] && any_on && xfer_i.burst && !xfer_i.last)
		|=> !burst_continue_out_n_o) else $error("burst in progress not shown");
	// Unused pin function code must leave the pin idle
	a_pf_unused: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(opt[0].pin_function == 2'h3) |=> cs_n_o[0]) else $error("unused function drove pin");
	a_we_pairs: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(xfer_i.valid && xfer_i.write && hit[0] && opt[1].pin_function == PF_WRITE
		&& opt[1].region == 3'h1) |=> !cs_n_o[1]) else $error("write enable not paired");
	c_read_hit: cover property (@(posedge clk_i) xfer_i.valid && !xfer_i.write && any_on);
	c_write_hit: cover property (@(posedge clk_i) xfer_i.valid && xfer_i.write && any_on);
	c_burst_last: cover property (@(posedge clk_i) xfer_i.last && any_on);
	c_reg_read: cover property (@(posedge clk_i) reg_rd_i ##1 reg_wr_i);
endmodule

// ===== tb/csb_sram_model.sv
`timescale 1ns/1ps
// ==========================================================
// Burst SRAM seen from its pins: latches the burst start address
module csb_sram_model (
	// Bus clock and pins
	input wire logic clk_i,
	input wire logic [31:0] bus_addr_i,
	input wire logic [3:0] byte_lane_enable_n_i,
	input wire logic chip_n_i,
	input wire logic transfer_start_strobe_n_i,
	input wire logic burst_continue_out_n_i,
	// Observed state
	output logic [1:0] sa_o,
	output logic [3:0] lane_write_n_o
);
	// No burst handshake returns: suppress input stays high, burst pin open
	// Strobe loads, advance steps only the two low bits
	always @(posedge clk_i) begin
		if (!chip_n_i && !transfer_start_strobe_n_i) begin
			sa_o <= {bus_addr_i[3], bus_addr_i[2]};
			lane_write_n_o <= byte_lane_enable_n_i;
		end else if (!chip_n_i && !burst_continue_out_n_i) begin
			sa_o <= sa_o + 2'h1; // Wraps inside the four-beat line
		end
	end
endmodule

// ===== tb/csb_port_bench.sv
`timescale 1ns/1ps
module csb_port_bench;
	import csb_pkg::*;
	// ==========================================================
	// Stimulus and observation
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, bus_addr, d;
	logic reg_wr = 1'b0, reg_rd = 1'b0, ts_n, bc_n, ack;
	csb_xfer_type xfer = '0;
	logic [3:0] lanes, lw_n;
	logic [2:0] cs_n;
	logic [1:0] sa;
	int fail_count = 0, tests_run = 0;
	localparam logic [31:0] B = 32'h00100000;
	always #4 clk_i = ~clk_i;
	csb_port #(.NUM_CS(3)) i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.xfer_i(xfer), .bus_addr_o(bus_addr), .byte_lane_enable_n_o(lanes), .cs_n_o(cs_n),
		.transfer_start_strobe_n_o(ts_n), .burst_continue_out_n_o(bc_n), .ack_enabled_o(ack));
	csb_sram_model i_mem (.clk_i(clk_i), .bus_addr_i(bus_addr), .byte_lane_enable_n_i(lanes),
		.chip_n_i(cs_n[0]), .transfer_start_strobe_n_i(ts_n), .burst_continue_out_n_i(bc_n),
		.sa_o(sa), .lane_write_n_o(lw_n));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		@(posedge clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// One transfer beat; pins are settled when this returns
	task automatic xf(input logic w, input logic [31:0] a, input logic [3:0] le,
		input logic b, input logic l);
		@(posedge clk_i);
		xfer <= '{valid: 1'b1, write: w, addr: a, lane_en: le, burst: b, last: l};
		@(posedge clk_i);
		xfer <= '0;
		#1;
	endtask
	function automatic logic [31:0] opt(input logic [3:0] dp, input logic ak,
		input logic [1:0] pw, input logic [1:0] pf, input logic [2:0] rg);
		return 32'({INTERFACE_TYPE_FIELD_SYNC_AOE, rg, 2'h0, pf, pw, ak, dp});
	endfunction
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("cs idle", 32'(cs_n), 32'h7);
		chk("lanes idle", 32'(lanes), 32'hf);
		rd(REGION1_OPTIONS, d);
		chk("opt1 reset", d, OPT_RESET);
		rd(SYSTEM_UNIT_CONFIG, d);
		chk("cfg reset", d, CFG_RESET);
		$display("test reset done");
	endtask
	// Reset in mid-run clears setup and idles every pin
	task automatic t_rereset();
		@(posedge clk_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		#1 chk("cs after reset", 32'(cs_n), 32'h7);
		chk("lanes after reset", 32'(lanes), 32'hf);
		rd(REGION1_BASE_ADDRESS, d);
		chk("base1 cleared", d, BASE_RESET);
		rd(SYSTEM_UNIT_CONFIG, d);
		chk("cfg cleared", d, CFG_RESET);
		xf(1'b0, B, 4'hf, 1'b0, 1'b0);
		chk("no hit after reset", 32'(cs_n), 32'h7);
		$display("test second reset done");
	endtask
	task automatic t_regs();
		wr(REGION2_OPTIONS, 32'hffffffff);
		rd(REGION2_OPTIONS, d);
		chk("opt2 width", d, 32'h0003ffff);
		@(posedge clk_i);
		#1 chk("rdata stands one", reg_rdata, 32'h0);
		wr(REGION3_BASE_ADDRESS, 32'ha5c3e71f);
		rd(REGION3_BASE_ADDRESS, d);
		chk("base3", d, 32'ha5c3e71f);
		wr(32'h8007fdf0, 32'h12345678);
		rd(32'h8007fdf0, d);
		chk("unmapped", d, 32'h0);
		$display("test registers done");
	endtask
	task automatic t_setup();
		wr(REGION1_BASE_ADDRESS, B);
		wr(REGION2_BASE_ADDRESS, B);
		wr(REGION3_BASE_ADDRESS, B);
		wr(REGION1_OPTIONS, opt(DEPTH_128K, 1'b0, PWIDTH_32, PF_CHIP, 3'h0));
		wr(REGION2_OPTIONS, opt(DEPTH_128K, 1'b0, PWIDTH_32, PF_WRITE, 3'h1));
		wr(REGION3_OPTIONS, opt(DEPTH_128K, 1'b0, PWIDTH_32, PF_OUTPUT, 3'h1));
		rd(BUS_STATUS, d);
		chk("interface_type_field status", 32'(d[8]), 32'h1);
		$display("test setup done");
	endtask
	task automatic t_pins();
		xf(1'b0, B + 32'h4, 4'hf, 1'b0, 1'b0);
		chk("read cs", 32'(cs_n), 32'h2);
		chk("read strobe", 32'(ts_n), 32'h0);
		chk("read addr", bus_addr, B + 32'h4);
		chk("ack off", 32'(ack), 32'h0);
		@(posedge clk_i);
		#1 chk("sram low addr", 32'(sa), 32'h1);
		xf(1'b1, B + 32'h1fffc, 4'h5, 1'b0, 1'b0);
		chk("write cs", 32'(cs_n), 32'h4);
		chk("write lanes", 32'(lanes), 32'ha);
		@(posedge clk_i);
		#1 chk("sram lanes", 32'(lw_n), 32'ha);
		xf(1'b1, B + 32'h20000, 4'hf, 1'b0, 1'b0);
		chk("above region", 32'({cs_n, ts_n, lanes}), 32'hff);
		xf(1'b0, B - 32'h4, 4'hf, 1'b0, 1'b0);
		chk("below region", 32'(cs_n), 32'h7);
		$display("test pins done");
	endtask
	task automatic t_modes();
		wr(REGION1_OPTIONS, opt(DEPTH_128K, 1'b1, PWIDTH_16, PF_CHIP, 3'h0));
		xf(1'b1, B, 4'hf, 1'b0, 1'b0);
		chk("ack on", 32'(ack), 32'h1);
		chk("x16 lanes", 32'(lanes), 32'hc);
		xf(1'b0, B + 32'h8, 4'hf, 1'b1, 1'b0);
		chk("burst mid", 32'(bc_n), 32'h0);
		xf(1'b0, B + 32'hc, 4'hf, 1'b1, 1'b1);
		chk("burst last", 32'(bc_n), 32'h1);
		wr(SYSTEM_UNIT_CONFIG, 32'h10);
		xf(1'b0, B + 32'h8, 4'hf, 1'b1, 1'b0);
		chk("final mid", 32'(bc_n), 32'h1);
		xf(1'b0, B + 32'hc, 4'hf, 1'b1, 1'b1);
		chk("final last", 32'(bc_n), 32'h0);
		// Code 11 leaves region 1 idle; its paired output enable still follows the hit
		wr(REGION1_OPTIONS, opt(DEPTH_128K, 1'b0, PWIDTH_32, 2'h3, 3'h0));
		xf(1'b0, B, 4'hf, 1'b0, 1'b0);
		chk("unused function", 32'(cs_n), 32'h3);
		$display("test modes done");
	endtask
	// ==========================================================
	// Verdict, watchdog and main sequence
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin // Run needs well under a thousand cycles
		#40000;
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'b1;
		#1;
		t_reset();
		t_regs();
		t_setup();
		t_pins();
		t_modes();
		t_rereset();
		end_sim();
	end
endmodule
